// ==== inc/audio_pcm_pkg.sv ====
/*
 Constants shared by the audio port control block and its FIFO:
 register offsets, control and status field positions, reset values.
 Assumes a 32-bit APB data path and byte addresses on PADDR.
*/
package audio_pcm_pkg;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 4;
    localparam int ADDR_W = 8;
    localparam int DIV_W = 8;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CLKDIV = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_TXD = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RXD = 8'h14;

    localparam int B_RXDMA = 21;
    localparam int B_TXDMA = 20;
    localparam int B_RXFL = 19;
    localparam int B_TXFL = 18;
    localparam int B_LZC = 17;
    localparam int B_RZC = 16;
    localparam int B_MCLK = 15;
    localparam int B_RX_FIFO_THRESHOLD_HI = 14;
    localparam int B_RX_FIFO_THRESHOLD_LO = 12;
    localparam int B_TX_FIFO_THRESHOLD_HI = 11;
    localparam int B_TX_FIFO_THRESHOLD_LO = 9;
    localparam int B_SLAVE = 8;
    localparam int B_FMT = 7;
    localparam int B_WID_HI = 5;
    localparam int B_WID_LO = 4;

    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h003f_ffff;
    localparam logic [DATA_W-1:0] FLUSH_BITS = 32'h000c_0000;
    localparam logic [DIV_W-1:0] CLKDIV_RESET = 8'h00;
    localparam logic [3:0] MASK_RESET = 4'h0;

    localparam int S_RX_FIFO_THRESHOLD = 0;
    localparam int S_TX_FIFO_THRESHOLD = 1;
    localparam int S_LZC = 2;
    localparam int S_RZC = 3;
    localparam int S_RXEMPTY = 4;
    localparam int S_TXFULL = 5;
    localparam int S_RXCNT = 8;
    localparam int S_TXCNT = 12;

    typedef enum logic [1:0] {
        WW_8 = 2'b00,
        WW_16 = 2'b01,
        WW_24 = 2'b10,
        WW_32 = 2'b11
    } word_width_t;
endpackage

// ==== rtl/pcm_fifo.sv ====
/*
 Small word FIFO with a pointer-only flush.
 Assumes DEPTH is a power of two and CW can hold DEPTH.
*/
`timescale 1ns/1ps
module pcm_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 8,
    parameter int CW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [W-1:0] push_data,
    input wire logic pop,
    output logic [W-1:0] head,
    output logic [CW-1:0] count,
    output logic [CW-1:0] nxt_count,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [CW-1:0] cnt_ff;
    logic do_push;
    logic do_pop;

    assign full = (cnt_ff == DEPTH_C);
    assign empty = (cnt_ff == '0);
    assign do_push = push && !full && !flush;
    assign do_pop = pop && !empty && !flush;
    assign head = mem[rd_ff];
    assign count = cnt_ff;

    always_comb begin
        nxt_count = cnt_ff;
        if (flush) begin
            nxt_count = '0;
        end else if (do_push && !do_pop) begin
            nxt_count = cnt_ff + 1'b1;
        end else if (do_pop && !do_push) begin
            nxt_count = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_count;
            if (flush) begin
                wr_ff <= '0; // R3 R4
                rd_ff <= '0;
            end else begin
                if (do_push) begin
                    wr_ff <= wr_ff + 1'b1;
                end
                if (do_pop) begin
                    rd_ff <= rd_ff + 1'b1;
                end
            end
        end
    end

    // Flush never touches storage; reset clears it so no unknowns leak
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (do_push) begin
            mem[wr_ff] <= push_data; // R5
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_flush_keeps;
        flush |=> $stable(mem[0]) && $stable(mem[DEPTH-1]);
    endproperty
    a_flush_keeps: assert property (p_flush_keeps) // R5
        else $error("flush altered FIFO storage");
endmodule

// ==== rtl/audio_pcm_ctrl.sv ====
/*
 Audio port control: APB register file, FIFO flush and DMA requests,
 zero-cross detection, codec clock output, role and format outputs.
 Assumes a serial engine on SYS_CLK feeds RX samples and pulls TX ones.
*/
`timescale 1ns/1ps
// How it works
// (R1) RX DMA request high while enabled and RX FIFO is not empty.
// (R2) TX DMA request high while enabled and TX FIFO has room.
// (R3) RX flush bit empties RX FIFO, resets pointers, self-clears.
// (R4) TX flush bit empties TX FIFO, resets pointers, self-clears.
// (R5) TX flush moves pointers only; stored words stay.
// (R6) Left flag sets on sign change or all-zero left sample when enabled.
// (R7) Right flag sets on sign change or all-zero right sample when enabled.
// (R8) Codec clock output runs only while its enable bit is one.
// (R9) Codec clock rate comes from the divider register field.
// (R10) Slave bit zero drives bit clock and frame sync; one releases them.
// (R11) RX threshold flag when RX count reaches threshold plus one.
// (R12) TX threshold flag when TX count is at or below threshold.
// (R13) Format bit selects I2S or MSB-justified framing for both paths.
// (R14) Zero-cross flags stick until written one; disabling keeps them.
// (R15) DMA requests drop at once when the condition goes away, one cycle after the enable clears.
module audio_pcm_ctrl (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [audio_pcm_pkg::ADDR_W-1:0] PADDR,
    input wire logic [audio_pcm_pkg::DATA_W-1:0] PWDATA,
    output logic [audio_pcm_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RX_SAMPLE_VALID,
    input wire logic RX_SAMPLE_RIGHT,
    input wire logic [audio_pcm_pkg::DATA_W-1:0] RX_SAMPLE,
    input wire logic TX_SAMPLE_REQ,
    output logic [audio_pcm_pkg::DATA_W-1:0] TX_SAMPLE,
    output logic TX_SAMPLE_VALID,
    output logic RX_DMA_REQ,
    output logic TX_DMA_REQ,
    output logic CODEC_CLK,
    output logic BCLK_OE,
    output logic FS_OE,
    output logic FORMAT_MSB,
    output logic [1:0] WORD_WIDTH,
    output logic IRQ
);
    import audio_pcm_pkg::*;

    logic [DATA_W-1:0] ctrl_ff;
    logic [DIV_W-1:0] clkdiv_ff;
    logic [3:0] mask_ff;
    logic lzc_ff;
    logic rzc_ff;
    logic lsign_ff;
    logic rsign_ff;
    logic rx_th_ff;
    logic tx_th_ff;
    logic [DIV_W-1:0] div_cnt_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [DATA_W-1:0] tx_sample_ff;
    logic tx_valid_ff;
    logic rx_dma_ff;
    logic tx_dma_ff;
    logic codec_clk_ff;
    logic bclk_oe_ff;
    logic fs_oe_ff;
    logic fmt_ff;
    logic [1:0] wid_ff;
    logic irq_ff;

    logic setup;
    logic wr_acc;
    logic rd_acc;
    logic wr_ctrl;
    logic wr_stat;
    logic [DATA_W-1:0] rd_word;
    logic map_hit;
    logic [DATA_W-1:0] stat_word;
    word_width_t width;
    logic samp_sign;
    logic samp_zero;
    logic lzc_set;
    logic rzc_set;

    logic [DATA_W-1:0] rx_head;
    logic [DATA_W-1:0] tx_head;
    logic [CNT_W-1:0] rx_count;
    logic [CNT_W-1:0] tx_count;
    logic [CNT_W-1:0] rx_nxt_count;
    logic [CNT_W-1:0] tx_nxt_count;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic [CNT_W-1:0] rx_th_level;
    logic [CNT_W-1:0] tx_th_level;

    function automatic logic [DATA_W-1:0] width_mask(word_width_t w);
        logic [DATA_W-1:0] m;
        m = 32'hffff_ffff;
        case (w)
            WW_8: m = 32'h0000_00ff;
            WW_16: m = 32'h0000_ffff;
            WW_24: m = 32'h00ff_ffff;
            default: m = 32'hffff_ffff;
        endcase
        return m;
    endfunction

    function automatic logic sign_of(logic [DATA_W-1:0] s, word_width_t w);
        logic [DATA_W-1:0] m;
        m = width_mask(w);
        return (s & (m ^ (m >> 1))) != 32'h0;
    endfunction

    function automatic logic is_zero(logic [DATA_W-1:0] s, word_width_t w);
        return (s & width_mask(w)) == 32'h0;
    endfunction

    assign setup = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && pready_ff && PWRITE;
    assign rd_acc = PSEL && PENABLE && pready_ff && !PWRITE;
    assign wr_ctrl = wr_acc && (PADDR == OFF_CTRL);
    assign wr_stat = wr_acc && (PADDR == OFF_STAT);
    assign tx_push = wr_acc && (PADDR == OFF_TXD);
    assign rx_pop = rd_acc && (PADDR == OFF_RXD);
    assign tx_pop = TX_SAMPLE_REQ && !tx_empty;
    assign width = word_width_t'(ctrl_ff[B_WID_HI:B_WID_LO]);

    pcm_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .CW(CNT_W)
    ) u_rx_fifo (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .flush(ctrl_ff[B_RXFL]),
        .push(RX_SAMPLE_VALID),
        .push_data(RX_SAMPLE),
        .pop(rx_pop),
        .head(rx_head),
        .count(rx_count),
        .nxt_count(rx_nxt_count),
        .full(),
        .empty(rx_empty)
    );

    pcm_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .CW(CNT_W)
    ) u_tx_fifo (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .flush(ctrl_ff[B_TXFL]),
        .push(tx_push),
        .push_data(PWDATA),
        .pop(tx_pop),
        .head(tx_head),
        .count(tx_count),
        .nxt_count(tx_nxt_count),
        .full(tx_full),
        .empty(tx_empty)
    );

    always_comb begin
        stat_word = '0;
        stat_word[S_RX_FIFO_THRESHOLD] = rx_th_ff;
        stat_word[S_TX_FIFO_THRESHOLD] = tx_th_ff;
        stat_word[S_LZC] = lzc_ff;
        stat_word[S_RZC] = rzc_ff;
        stat_word[S_RXEMPTY] = rx_empty;
        stat_word[S_TXFULL] = tx_full;
        stat_word[S_RXCNT +: CNT_W] = rx_count;
        stat_word[S_TXCNT +: CNT_W] = tx_count;
    end

    always_comb begin
        rd_word = '0;
        map_hit = 1'b1;
        if (PADDR == OFF_CTRL) begin
            rd_word = ctrl_ff;
        end else if (PADDR == OFF_CLKDIV) begin
            rd_word[DIV_W-1:0] = clkdiv_ff;
        end else if (PADDR == OFF_MASK) begin
            rd_word[3:0] = mask_ff;
        end else if (PADDR == OFF_STAT) begin
            rd_word = stat_word;
        end else if (PADDR == OFF_TXD) begin
            rd_word = '0;
        end else if (PADDR == OFF_RXD) begin
            rd_word = rx_empty ? '0 : rx_head;
        end else begin
            map_hit = 1'b0;
        end
    end

    // Read data is caught in setup so the access phase needs no wait
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !map_hit;
            if (setup) begin
                prdata_ff <= rd_word;
            end
        end
    end

    // Flush bits live one cycle: that cycle is the flush itself
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= PWDATA & CTRL_WMASK;
        end else begin
            ctrl_ff <= ctrl_ff & ~FLUSH_BITS; // R3 R4
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clkdiv_ff <= CLKDIV_RESET;
            mask_ff <= MASK_RESET;
        end else if (wr_acc) begin
            if (PADDR == OFF_CLKDIV) begin
                clkdiv_ff <= PWDATA[DIV_W-1:0];
            end else if (PADDR == OFF_MASK) begin
                mask_ff <= PWDATA[3:0];
            end
        end
    end

    assign samp_sign = sign_of(RX_SAMPLE, width);
    assign samp_zero = is_zero(RX_SAMPLE, width);
    assign lzc_set = RX_SAMPLE_VALID && !RX_SAMPLE_RIGHT &&
        ctrl_ff[B_LZC] && (samp_sign != lsign_ff || samp_zero); // R6
    assign rzc_set = RX_SAMPLE_VALID && RX_SAMPLE_RIGHT &&
        ctrl_ff[B_RZC] && (samp_sign != rsign_ff || samp_zero); // R7

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lsign_ff <= 1'b0;
            rsign_ff <= 1'b0;
        end else if (RX_SAMPLE_VALID) begin
            if (RX_SAMPLE_RIGHT) begin
                rsign_ff <= samp_sign;
            end else begin
                lsign_ff <= samp_sign;
            end
        end
    end

    // New detection beats a same-cycle clear
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lzc_ff <= 1'b0;
            rzc_ff <= 1'b0;
        end else begin
            lzc_ff <= lzc_set || (lzc_ff && !(wr_stat && PWDATA[S_LZC])); // R14
            rzc_ff <= rzc_set || (rzc_ff && !(wr_stat && PWDATA[S_RZC])); // R14
        end
    end

    assign rx_th_level = CNT_W'(ctrl_ff[B_RX_FIFO_THRESHOLD_HI:B_RX_FIFO_THRESHOLD_LO]) + 1'b1;
    assign tx_th_level = CNT_W'(ctrl_ff[B_TX_FIFO_THRESHOLD_HI:B_TX_FIFO_THRESHOLD_LO]);

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_th_ff <= 1'b0;
            tx_th_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            rx_th_ff <= rx_count >= rx_th_level; // R11
            tx_th_ff <= tx_count <= tx_th_level; // R12
            irq_ff <= |(stat_word[3:0] & mask_ff);
        end
    end

    // Next counts keep a request from outliving its last word or slot
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_dma_ff <= 1'b0;
            tx_dma_ff <= 1'b0;
        end else begin
            rx_dma_ff <= ctrl_ff[B_RXDMA] && (rx_nxt_count != '0); // R1 R15
            tx_dma_ff <= ctrl_ff[B_TXDMA] &&
                (tx_nxt_count != CNT_W'(FIFO_DEPTH)); // R2 R15
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_sample_ff <= '0;
            tx_valid_ff <= 1'b0;
        end else begin
            tx_valid_ff <= tx_pop;
            if (tx_pop) begin
                tx_sample_ff <= tx_head;
            end
        end
    end

    // Half period is divider plus one system clocks
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_cnt_ff <= '0;
            codec_clk_ff <= 1'b0;
        end else if (!ctrl_ff[B_MCLK]) begin
            div_cnt_ff <= '0; // R8
            codec_clk_ff <= 1'b0;
        end else if (div_cnt_ff == clkdiv_ff) begin
            div_cnt_ff <= '0; // R9
            codec_clk_ff <= !codec_clk_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bclk_oe_ff <= 1'b0;
            fs_oe_ff <= 1'b0;
            fmt_ff <= 1'b0;
            wid_ff <= 2'h0;
        end else begin
            bclk_oe_ff <= !ctrl_ff[B_SLAVE]; // R10
            fs_oe_ff <= !ctrl_ff[B_SLAVE]; // R10
            fmt_ff <= ctrl_ff[B_FMT]; // R13
            wid_ff <= ctrl_ff[B_WID_HI:B_WID_LO];
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign TX_SAMPLE = tx_sample_ff;
    assign TX_SAMPLE_VALID = tx_valid_ff;
    assign RX_DMA_REQ = rx_dma_ff;
    assign TX_DMA_REQ = tx_dma_ff;
    assign CODEC_CLK = codec_clk_ff;
    assign BCLK_OE = bclk_oe_ff;
    assign FS_OE = fs_oe_ff;
    assign FORMAT_MSB = fmt_ff;
    assign WORD_WIDTH = wid_ff;
    assign IRQ = irq_ff;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    property p_rx_dma_safe;
        RX_DMA_REQ |-> (rx_count != '0) && $past(ctrl_ff[B_RXDMA]);
    endproperty
    a_rx_dma_safe: assert property (p_rx_dma_safe) // R15
        else $error("RX DMA request without data or enable");

    property p_rx_dma_on;
        (ctrl_ff[B_RXDMA] && rx_count != '0)[*2] |-> RX_DMA_REQ;
    endproperty
    a_rx_dma_on: assert property (p_rx_dma_on) // R1
        else $error("RX DMA request missing");

    property p_tx_dma_on;
        (ctrl_ff[B_TXDMA] && !tx_full)[*2] |-> TX_DMA_REQ;
    endproperty
    a_tx_dma_on: assert property (p_tx_dma_on) // R2
        else $error("TX DMA request missing");

    property p_tx_dma_safe;
        TX_DMA_REQ |-> !tx_full;
    endproperty
    a_tx_dma_safe: assert property (p_tx_dma_safe) // R15
        else $error("TX DMA request with FIFO full");

    property p_rx_flush;
        ctrl_ff[B_RXFL] && !wr_ctrl |=> rx_empty && !ctrl_ff[B_RXFL];
    endproperty
    a_rx_flush: assert property (p_rx_flush) // R3
        else $error("RX flush did not empty or self-clear");

    property p_tx_flush;
        wr_ctrl && PWDATA[B_TXFL] ##1 !wr_ctrl |=> tx_empty && !ctrl_ff[B_TXFL];
    endproperty
    a_tx_flush: assert property (p_tx_flush) // R4
        else $error("TX flush did not empty or self-clear");

    property p_lzc;
        RX_SAMPLE_VALID && !RX_SAMPLE_RIGHT && ctrl_ff[B_LZC] && samp_zero
            |=> lzc_ff;
    endproperty
    a_lzc: assert property (p_lzc) // R6
        else $error("left zero sample did not set flag");

    property p_rzc_sign;
        RX_SAMPLE_VALID && RX_SAMPLE_RIGHT && ctrl_ff[B_RZC] &&
            (samp_sign != rsign_ff) |=> rzc_ff;
    endproperty
    a_rzc_sign: assert property (p_rzc_sign) // R7
        else $error("right sign change did not set flag");

    property p_zc_sticky;
        lzc_ff && !(wr_stat && PWDATA[S_LZC]) |=> lzc_ff;
    endproperty
    a_zc_sticky: assert property (p_zc_sticky) // R14
        else $error("left zero-cross flag dropped without clear");

    property p_codec_off;
        !ctrl_ff[B_MCLK] |=> !CODEC_CLK;
    endproperty
    a_codec_off: assert property (p_codec_off) // R8
        else $error("codec clock runs while disabled");

    property p_codec_rate;
        ctrl_ff[B_MCLK] && $past(ctrl_ff[B_MCLK]) && $changed(CODEC_CLK)
            |-> $past(div_cnt_ff) == $past(clkdiv_ff);
    endproperty
    a_codec_rate: assert property (p_codec_rate) // R9
        else $error("codec clock edge off divider count");

    property p_role;
        ctrl_ff[B_SLAVE][*2] |-> !BCLK_OE && !FS_OE;
    endproperty
    a_role: assert property (p_role) // R10
        else $error("pins driven in slave role");

    property p_rx_fifo_threshold;
        ##1 rx_th_ff == ($past(rx_count) >= $past(rx_th_level));
    endproperty
    a_rx_fifo_threshold: assert property (p_rx_fifo_threshold) // R11
        else $error("RX threshold flag wrong");
endmodule

// ==== verif/serial_engine_model.sv ====
/*
 Stand-in for the serial engine on the sample ports of the audio port.
 Assumes the bench calls its tasks from one thread, clocked by SYS_CLK.
*/
`timescale 1ns/1ps
module serial_engine_model (
    input wire logic clk,
    output logic rx_valid,
    output logic rx_right,
    output logic [31:0] rx_sample,
    output logic tx_req,
    input wire logic [31:0] tx_sample,
    input wire logic tx_valid
);
    initial begin
        rx_valid = 1'b0;
        rx_right = 1'b0;
        rx_sample = 32'h5a5a_a5a5;
        tx_req = 1'b0;
    end

    // Bus shows inverted junk outside the strobe, never the old sample
    task automatic send(input logic right, input logic [31:0] d);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_right <= right;
        rx_sample <= d;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_sample <= ~d;
    endtask

    task automatic pull(output logic [31:0] d, output logic ok);
        ok = 1'b0;
        d = 32'h0;
        @(posedge clk);
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        repeat (3) begin
            @(negedge clk);
            if (!ok && tx_valid === 1'b1) begin
                ok = 1'b1;
                d = tx_sample;
            end
        end
    endtask
endmodule

// ==== verif/audio_pcm_ctrl_test.sv ====
/*
 Self-checking bench for audio_pcm_ctrl: APB master task, serial engine
 model on the sample ports, table of control writes, then hand cases.
 Assumes a 50 MHz SYS_CLK and the package's offsets and bit positions.
*/
`timescale 1ns/1ps
module audio_pcm_ctrl_test;
    import audio_pcm_pkg::*;
    logic SYS_CLK, RESET_N, PSEL, PENABLE, PWRITE;
    logic [ADDR_W-1:0] PADDR;
    logic [DATA_W-1:0] PWDATA, PRDATA, RX_SAMPLE, TX_SAMPLE;
    logic PREADY, PSLVERR, RX_SAMPLE_VALID, RX_SAMPLE_RIGHT, TX_SAMPLE_REQ;
    logic TX_SAMPLE_VALID, RX_DMA_REQ, TX_DMA_REQ, CODEC_CLK, BCLK_OE;
    logic FS_OE, FORMAT_MSB, IRQ, err, ok, last;
    logic [1:0] WORD_WIDTH;
    logic [31:0] rd;
    logic [67:0] rows [3];
    int miscompares = 0;
    int compares = 0;
    int i, j, k;

    audio_pcm_ctrl u_audio_pcm_ctrl (
        .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RX_SAMPLE_VALID(RX_SAMPLE_VALID),
        .RX_SAMPLE_RIGHT(RX_SAMPLE_RIGHT), .RX_SAMPLE(RX_SAMPLE),
        .TX_SAMPLE_REQ(TX_SAMPLE_REQ), .TX_SAMPLE(TX_SAMPLE),
        .TX_SAMPLE_VALID(TX_SAMPLE_VALID), .RX_DMA_REQ(RX_DMA_REQ),
        .TX_DMA_REQ(TX_DMA_REQ), .CODEC_CLK(CODEC_CLK),
        .BCLK_OE(BCLK_OE), .FS_OE(FS_OE), .FORMAT_MSB(FORMAT_MSB),
        .WORD_WIDTH(WORD_WIDTH), .IRQ(IRQ)
    );

    serial_engine_model u_serial_engine_model (
        .clk(SYS_CLK), .rx_valid(RX_SAMPLE_VALID),
        .rx_right(RX_SAMPLE_RIGHT), .rx_sample(RX_SAMPLE),
        .tx_req(TX_SAMPLE_REQ), .tx_sample(TX_SAMPLE),
        .tx_valid(TX_SAMPLE_VALID)
    );

    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Request held until PREADY seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge SYS_CLK);
            if (PREADY === 1'b1) break;
        end
        if (k == 20) begin
            miscompares++;
            end_sim();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // Returns mid-cycle so callers look at settled outputs
        @(negedge SYS_CLK);
    endtask

    task automatic settle();
        repeat (2) @(negedge SYS_CLK);
    endtask

    initial begin
        RESET_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        last = 1'b0;
        j = 0;
        rows[0] = {32'h0000_01b0, 32'h0000_01b0, 1'b1, 2'b11, 1'b0};
        rows[1] = {32'hffc0_0020, 32'h0000_0020, 1'b0, 2'b10, 1'b1};
        rows[2] = {32'h0000_0090, 32'h0000_0090, 1'b1, 2'b01, 1'b1};
        repeat (5) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        settle();
        chk("bclk_oe_reset", 32'h1, BCLK_OE);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, OFF_CTRL, rows[i][67:36]);
            apb(1'b0, OFF_CTRL, 32'h0);
            chk("ctrl", rows[i][35:4], rd);
            chk("format", rows[i][3], FORMAT_MSB);
            chk("width", rows[i][2:1], WORD_WIDTH);
            chk("bclk_oe", rows[i][0], BCLK_OE);
            chk("fs_oe", rows[i][0], FS_OE);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", 32'h1, err);
        chk("unmapped", 32'h0, rd);
        // Zero-cross on 8-bit samples: left all-zero, right sign flip
        apb(1'b1, OFF_MASK, 32'h0000_000c);
        apb(1'b1, OFF_CTRL, 32'h0003_0000);
        u_serial_engine_model.send(1'b0, 32'h0);
        u_serial_engine_model.send(1'b1, 32'h80);
        apb(1'b0, OFF_STAT, 32'h0);
        chk("stat_zc", 32'hf, rd[3:0]);
        chk("irq", 32'h1, IRQ);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_STAT, 32'h4);
        u_serial_engine_model.send(1'b0, 32'h0);
        apb(1'b0, OFF_STAT, 32'h0);
        chk("stat_kept", 32'hb, rd[3:0]);
        apb(1'b1, OFF_MASK, 32'h0);
        settle();
        chk("irq_masked", 32'h0, IRQ);
        apb(1'b1, OFF_STAT, 32'h8);
        apb(1'b0, OFF_STAT, 32'h0);
        chk("stat_clr", 32'h3, rd[3:0]);
        apb(1'b1, OFF_CTRL, 32'h0020_0000);
        settle();
        chk("rx_dma", 32'h1, RX_DMA_REQ);
        for (i = 0; i < 3; i++) begin
            apb(1'b0, OFF_RXD, 32'h0);
            chk("rx_word", (i == 1) ? 32'h80 : 32'h0, rd);
        end
        settle();
        chk("rx_dma_empty", 32'h0, RX_DMA_REQ);
        u_serial_engine_model.send(1'b0, 32'h1234_5678);
        apb(1'b1, OFF_CTRL, 32'h0028_0000);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("rx_flush_bit", 32'h0020_0000, rd);
        apb(1'b0, OFF_STAT, 32'h0);
        chk("rx_count", 32'h0, rd[11:8]);
        chk("rx_dma_flush", 32'h0, RX_DMA_REQ);
        apb(1'b1, OFF_CTRL, 32'h0010_0000);
        settle();
        chk("tx_dma", 32'h1, TX_DMA_REQ);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, OFF_TXD, 32'ha0 + i);
        end
        settle();
        chk("tx_dma_full", 32'h0, TX_DMA_REQ);
        u_serial_engine_model.pull(rd, ok);
        chk("tx_word", 32'ha0, rd);
        chk("tx_valid", 32'h1, ok);
        settle();
        chk("tx_dma_room", 32'h1, TX_DMA_REQ);
        apb(1'b1, OFF_CTRL, 32'h0014_0000);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("tx_flush_bit", 32'h0010_0000, rd);
        apb(1'b0, OFF_STAT, 32'h0);
        chk("tx_count", 32'h0, rd[15:12]);
        chk("tx_thr", 32'h1, rd[1]);
        // Threshold 2 means three words are needed
        apb(1'b1, OFF_CTRL, 32'h0000_2000);
        for (i = 0; i < 3; i++) begin
            u_serial_engine_model.send(1'b0, 32'h7);
            apb(1'b0, OFF_STAT, 32'h0);
            chk("rx_thr", (i == 2), rd[0]);
        end
        apb(1'b1, OFF_CLKDIV, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h0000_8000);
        for (i = 0; i < 12; i++) begin
            @(negedge SYS_CLK);
            if (i > 0 && CODEC_CLK !== last) begin
                if (j > 0) chk("mclk_gap", 32'h2, i - j);
                j = i;
            end
            last = CODEC_CLK;
        end
        chk("mclk_ran", 32'h1, j > 0);
        apb(1'b1, OFF_CTRL, 32'h0);
        settle();
        for (i = 0; i < 4; i++) begin
            @(negedge SYS_CLK);
            chk("mclk_off", 32'h0, CODEC_CLK);
        end
        end_sim();
    end
endmodule
